// File: src/lin_transceiver_mode_control.sv
// digital mode control and data-path gating of a single-wire LIN
// transceiver; assumes an APB master on clock, async pins on the
// transmit input and bus receiver, and the device mode from same-clock logic
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "lin_mode_map.svh"

// Functional notes
// - Reset starts in off mode; off stops the driver in any device mode.
// - Off mode ignores bus wake patterns: no flag, no state change.
// - Software mode field selects the applied mode; device Failsafe forces wake, and normal or receive-only fall back to off outside device Normal or Stop.
// - Normal mode only takes effect in device Normal or Stop mode.
// - After enable delay, transmit low drives bus dominant, high releases it.
// - With reception active the receive output follows the bus level.
// - Early dominant is dropped; only the next dominant after a high passes.
// - Receive-only keeps the driver off but still passes the bus level.
// - Receive-only is set by software, only in device Normal or Stop.
// - Wake: falling edge, dominant beyond filter time, then rising edge.
// - After wake the mode stays wake-capable and receive output stays low.
// - Long dominant transmit disables the driver and flags a fault.
module lin_transceiver_mode_control #(
  parameter int unsigned EN_CYC = `LIN_EN_CYC,
  parameter int unsigned WK_CYC = `LIN_WK_CYC,
  parameter int unsigned TXTO_CYC = `LIN_TXTO_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device operating mode
  input wire lin_mode_pkg::dev_mode_e dev_mode,
  // microcontroller pins
  input wire logic lin_tx_input,
  output logic lin_rx_output,
  // open-drain bus pin
  input wire logic bus_in,
  output logic bus_out,
  output logic bus_oe,
  // interrupt
  output logic irq
);
  import lin_mode_pkg::*;

  state_s s;
  state_s n;
  logic [1:0] em;
  logic tx;
  logic bus;
  logic acc;
  logic ctrl_wr;
  logic ev_wake;
  logic ev_to;
  logic [1:0] clr;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic dev_active(input dev_mode_e d);
    return (d == DEV_NORMAL) || (d == DEV_STOP);
  endfunction

  function automatic logic [1:0] eff_mode(input logic [1:0] m, input dev_mode_e d);
    logic [1:0] r;
    r = m;
    if (d == DEV_FAILSAFE) begin
      r = `LIN_MODE_WAKE;
    end else if ((m == `LIN_MODE_NORM || m == `LIN_MODE_RXO) && !dev_active(d)) begin
      r = `LIN_MODE_OFF;
    end
    return r;
  endfunction

  function automatic logic map_hit(input logic [7:0] a);
    return (a == `LIN_CTRL_OFS) || (a == `LIN_STAT_OFS) ||
           (a == `LIN_MASK_OFS) || (a == `LIN_INFO_OFS);
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = s;
    tx = s.tx_sy[1];
    bus = s.bus_sy[1];
    em = eff_mode(s.mode, dev_mode);
    ev_wake = 1'b0;
    ev_to = 1'b0;
    clr = 2'h0;
    n.tx_sy = {s.tx_sy[0], lin_tx_input};
    n.bus_sy = {s.bus_sy[0], bus_in};
    n.bus_out = 1'b0;

    // one wait state keeps prdata and pready both registered
    acc = psel & penable & s.pready;
    ctrl_wr = acc & pwrite & (paddr == `LIN_CTRL_OFS);
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (psel & penable & ~s.pready) begin
      n.pready = 1'b1;
      n.pslverr = ~map_hit(paddr);
      n.prdata = 32'h0;
      unique case (paddr)
        `LIN_CTRL_OFS: n.prdata[`LIN_MODE_MSB:`LIN_MODE_LSB] = s.mode;
        `LIN_STAT_OFS: n.prdata[1:0] = s.status;
        `LIN_MASK_OFS: n.prdata[1:0] = s.mask;
        `LIN_INFO_OFS: n.prdata[5:0] = {s.to_fault, s.tx_perm, s.woken, s.drv, em};
        default: n.prdata = 32'h0;
      endcase
    end
    if (ctrl_wr) begin
      if (pwdata[`LIN_MODE_MSB:`LIN_MODE_LSB] != s.mode) begin
        n.woken = 1'b0;
      end
      n.mode = pwdata[`LIN_MODE_MSB:`LIN_MODE_LSB];
    end
    if (acc & pwrite & (paddr == `LIN_MASK_OFS)) begin
      n.mask = pwdata[1:0];
    end
    if (acc & ~pwrite & (paddr == `LIN_STAT_OFS)) begin
      clr = s.status;
    end
    // entering a low-power or safe device mode rearms wake
    if (dev_mode != s.dev_prev && !(dev_mode == DEV_NORMAL || dev_mode == DEV_RESTART)) begin
      n.woken = 1'b0;
    end
    n.dev_prev = dev_mode;

    n.norm_prev = (em == `LIN_MODE_NORM);
    if (em != `LIN_MODE_NORM || !s.norm_prev) begin
      n.en_cnt = 32'h0;
      n.tx_perm = 1'b0;
    end else if (s.en_cnt < EN_CYC) begin
      n.en_cnt = s.en_cnt + 32'h1;
    end else if (tx) begin
      // permit only after the input is back high
      n.tx_perm = 1'b1;
    end

    if (em == `LIN_MODE_NORM && !tx) begin
      if (s.to_cnt < TXTO_CYC) begin
        n.to_cnt = s.to_cnt + 32'h1;
      end else if (!s.to_fault) begin
        n.to_fault = 1'b1;
        ev_to = 1'b1;
      end
    end else begin
      n.to_cnt = 32'h0;
      n.to_fault = 1'b0;
    end

    n.drv = (em == `LIN_MODE_NORM) && s.tx_perm && !tx && !s.to_fault;

    if (em != `LIN_MODE_WAKE || s.woken) begin
      n.wk = WK_IDLE;
      n.wk_cnt = 32'h0;
    end else begin
      unique case (s.wk)
        WK_IDLE: begin
          if (bus) begin
            n.wk = WK_REC;
          end
        end
        WK_REC: begin
          if (!bus) begin
            n.wk = WK_DOM;
            n.wk_cnt = 32'h0;
          end
        end
        WK_DOM: begin
          if (bus) begin
            n.wk = WK_REC;
          end else if (s.wk_cnt >= WK_CYC) begin
            n.wk = WK_LONG;
          end else begin
            n.wk_cnt = s.wk_cnt + 32'h1;
          end
        end
        WK_LONG: begin
          if (bus) begin
            n.wk = WK_REC;
            n.woken = 1'b1;
            ev_wake = 1'b1;
          end
        end
      endcase
    end

    unique case (em)
      `LIN_MODE_NORM, `LIN_MODE_RXO: n.rx_out = bus;
      `LIN_MODE_WAKE: n.rx_out = ~n.woken;
      default: n.rx_out = 1'b1;
    endcase

    // a status event in the clearing cycle survives
    n.status = (s.status & ~clr) | {ev_to, ev_wake};
    n.irq = |(n.status & n.mask);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.mode <= `LIN_MODE_RST;
      s.mask <= `LIN_MASK_RST;
      s.wk <= WK_IDLE;
      s.rx_out <= 1'b1;
      s.tx_sy <= 2'h3;
      s.bus_sy <= 2'h3;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign lin_rx_output = s.rx_out;
  assign bus_out = s.bus_out;
  assign bus_oe = s.drv;
  assign irq = s.irq;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence long_dom_s;
    s.wk == WK_LONG && em == `LIN_MODE_WAKE && !s.woken;
  endsequence

  sequence release_s;
    bus && !ctrl_wr;
  endsequence

  off_no_drive_a: assert property (
    em == `LIN_MODE_OFF |=> !bus_oe)
    else $error("driver active in off mode");

  off_no_wake_a: assert property (
    em == `LIN_MODE_OFF |-> !ev_wake && n.wk == WK_IDLE)
    else $error("wake seen in off mode");

  mode_write_a: assert property (
    ctrl_wr |=> s.mode == $past(pwdata[1:0]))
    else $error("mode field not written");

  norm_gate_a: assert property (
    em == `LIN_MODE_NORM |-> dev_active(dev_mode))
    else $error("normal mode in wrong device mode");

  tx_drive_a: assert property (
    em == `LIN_MODE_NORM && s.tx_perm && !s.to_fault && !tx |=> bus_oe)
    else $error("dominant not driven");

  rx_follow_a: assert property (
    em == `LIN_MODE_NORM || em == `LIN_MODE_RXO |=> lin_rx_output == $past(bus))
    else $error("receive output does not follow bus");

  early_block_a: assert property (
    $rose(em == `LIN_MODE_NORM) |-> ##1 (!s.tx_perm && !bus_oe) [*4])
    else $error("drive before enable delay");

  rxo_quiet_a: assert property (
    em == `LIN_MODE_RXO |=> !bus_oe)
    else $error("driver active in receive-only");

  rxo_gate_a: assert property (
    em == `LIN_MODE_RXO |-> dev_active(dev_mode) && s.mode == `LIN_MODE_RXO)
    else $error("receive-only in wrong device mode");

  permit_gate_a: assert property (
    bus_oe |-> $past(s.tx_perm) && $past(s.en_cnt) == EN_CYC)
    else $error("drive without permit");

  wake_take_a: assert property (
    long_dom_s ##0 release_s |=> s.woken && s.status[`LIN_EV_WAKE])
    else $error("wake not taken on release edge");

  // a mode write or a rearming device mode change legally ends the hold
  wake_hold_a: assert property (
    s.woken && em == `LIN_MODE_WAKE && !ctrl_wr && dev_mode == s.dev_prev
      |=> !lin_rx_output && s.mode == `LIN_MODE_WAKE)
    else $error("receive output released after wake");

  txto_fault_a: assert property (
    s.to_fault |=> !bus_oe)
    else $error("time-out did not disable driver");

  // the flag may be read-cleared while the fault still stands
  txto_flag_a: assert property (
    $rose(s.to_fault) |-> s.status[`LIN_EV_TXTO])
    else $error("time-out fault not flagged");

endmodule
`default_nettype wire

// File: src/lin_mode_map.svh
// offsets, field positions, reset values and timing counts of the
// LIN mode control block; assumes a 125 MHz clock and a 32-bit APB
`ifndef LIN_MODE_MAP_SVH
`define LIN_MODE_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define LIN_CTRL_OFS 8'h00
`define LIN_STAT_OFS 8'h04
`define LIN_MASK_OFS 8'h08
`define LIN_INFO_OFS 8'h0C

// ----------------------------------------
// fields
// ----------------------------------------
`define LIN_MODE_LSB 0
`define LIN_MODE_MSB 1
`define LIN_EV_WAKE 0
`define LIN_EV_TXTO 1
`define LIN_MODE_OFF 2'h0
`define LIN_MODE_WAKE 2'h1
`define LIN_MODE_RXO 2'h2
`define LIN_MODE_NORM 2'h3
`define LIN_MODE_RST `LIN_MODE_OFF
`define LIN_MASK_RST 2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define LIN_CLK_MHZ 125
`define LIN_EN_TIME_NS 10000
`define LIN_WK_FILT_NS 30000
`define LIN_TXTO_US 20000
// least times round up, counts in clock cycles
`define LIN_EN_CYC ((`LIN_EN_TIME_NS * `LIN_CLK_MHZ + 999) / 1000)
`define LIN_WK_CYC ((`LIN_WK_FILT_NS * `LIN_CLK_MHZ + 999) / 1000)
`define LIN_TXTO_CYC (`LIN_TXTO_US * `LIN_CLK_MHZ)

`endif

// File: src/lin_mode_pkg.sv
// types of the LIN mode control block; the numbers live in the map header
package lin_mode_pkg;

  typedef enum logic [2:0] {
    DEV_NORMAL = 3'h0,
    DEV_STOP = 3'h1,
    DEV_SLEEP = 3'h2,
    DEV_RESTART = 3'h3,
    DEV_FAILSAFE = 3'h4
  } dev_mode_e;

  typedef enum logic [3:0] {
    WK_IDLE = 4'h1,
    WK_REC = 4'h2,
    WK_DOM = 4'h4,
    WK_LONG = 4'h8
  } wk_e;

  typedef struct packed {
    logic [1:0] mode;
    logic woken;
    logic [31:0] en_cnt;
    logic tx_perm;
    logic [31:0] to_cnt;
    logic to_fault;
    wk_e wk;
    logic [31:0] wk_cnt;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    logic rx_out;
    logic drv;
    logic bus_out;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] tx_sy;
    logic [1:0] bus_sy;
    dev_mode_e dev_prev;
    logic norm_prev;
  } state_s;

endpackage

// File: dv/lin_mcu_model.sv
// controller pin model: drives the transmit input of the LIN mode control
// assumes bench requests by non-blocking assignment at rising edges
`timescale 1ns/1ns
`default_nettype none
module lin_mcu_model #(
  parameter int HOLD_CYC = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // bench requests; rude skips the recessive hold on purpose
  input wire logic send,
  input wire logic en_start,
  input wire logic rude,
  // pin
  output logic tx
);
  int hold_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hold_r <= 0;
      tx <= 1'h1;
    end else begin
      hold_r <= en_start ? HOLD_CYC : (hold_r > 0 ? hold_r - 1 : 0);
      tx <= ((hold_r > 0 || en_start) && !rude) ? 1'h1 : send;
    end
  end
endmodule
`default_nettype wire

// File: dv/lin_transceiver_mode_control_tb.sv
// self-checking bench of the LIN mode control block
// assumes the design under src and the controller model under dv
`timescale 1ns/1ns
`default_nettype none
`include "lin_mode_map.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; \
  $display("ERROR %s exp %0h got %0h", n, e, s); end end
module lin_transceiver_mode_control_tb;
  import lin_mode_pkg::*;
  // ----------------------------------------
  // set-up; small counts keep the run short
  // ----------------------------------------
  localparam int EN = 8;
  localparam int WK = 10;
  localparam int TO = 50;
  logic clock = 1'h0, reset_n = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, tx, rx, bus_in, bus_out, bus_oe, irq;
  logic send = 1'h1, en_start = 1'h0, rude = 1'h0, remote = 1'h0;
  dev_mode_e dev_mode = DEV_NORMAL;
  int fails = 0, checked = 0;
  // pulled-up wire: dominant when either node pulls it low
  assign bus_in = !((bus_oe && !bus_out) || remote);
  lin_transceiver_mode_control #(.EN_CYC(EN), .WK_CYC(WK), .TXTO_CYC(TO)) uut (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dev_mode(dev_mode),
    .lin_tx_input(tx), .lin_rx_output(rx), .bus_in(bus_in),
    .bus_out(bus_out), .bus_oe(bus_oe), .irq(irq));
  lin_mcu_model #(.HOLD_CYC(EN + 8)) mcu (.clock(clock), .reset_n(reset_n),
    .send(send), .en_start(en_start), .rude(rude), .tx(tx));
  // ----------------------------------------
  // bus and pin tasks
  // ----------------------------------------
  task automatic w(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    // pready is read at the rising edge, before that edge updates it
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                    input string n);
    logic [31:0] q;
    logic e;
    apb(1'h0, a, 32'h0, q, e);
    `CHK(n, x, q & m)
  endtask
  task automatic pin(input logic s, input logic d);
    @(posedge clock);
    send <= s;
    remote <= d;
  endtask
  task automatic mode(input dev_mode_e m);
    @(posedge clock);
    dev_mode <= m;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset;
    logic [31:0] q;
    logic e;
    `CHK("rx", 1'h1, rx)
    `CHK("bus_out", 1'h0, bus_out)
    rd(`LIN_CTRL_OFS, 32'h3, 32'h0, "ctrl");
    rd(`LIN_MASK_OFS, 32'hFFFFFFFF, 32'h0, "mask");
    apb(1'h0, 8'h10, 32'h0, q, e);
    `CHK("unmapped", 1'h1, e)
  endtask
  task automatic test_off;
    pin(1'h0, 1'h1);
    w(WK + 10);
    `CHK("off_drv", 1'h0, bus_oe)
    pin(1'h1, 1'h0);
    w(5);
    rd(`LIN_STAT_OFS, 32'h3, 32'h0, "status");
    rd(`LIN_INFO_OFS, 32'h8, 32'h0, "woken");
  endtask
  task automatic test_norm;
    wr(`LIN_CTRL_OFS, 32'h3);
    @(posedge clock);
    en_start <= 1'h1;
    send <= 1'h0;
    @(posedge clock);
    en_start <= 1'h0;
    w(EN + 24);
    `CHK("drive", 1'h1, bus_oe)
    `CHK("rx", 1'h0, rx)
    w(TO + 10);
    `CHK("timeout", 1'h0, bus_oe)
    rd(`LIN_STAT_OFS, 32'h3, 32'h2, "status");
    pin(1'h1, 1'h0);
    w(5);
    `CHK("rx", 1'h1, rx)
    pin(1'h0, 1'h0);
    w(5);
    `CHK("redrive", 1'h1, bus_oe)
    rd(`LIN_CTRL_OFS, 32'h3, 32'h3, "ctrl");
    pin(1'h1, 1'h0);
    wr(`LIN_CTRL_OFS, 32'h0);
    wr(`LIN_CTRL_OFS, 32'h3);
    @(posedge clock);
    rude <= 1'h1;
    send <= 1'h0;
    w(EN + 10);
    `CHK("early", 1'h0, bus_oe)
    pin(1'h1, 1'h0);
    w(5);
    pin(1'h0, 1'h0);
    w(5);
    `CHK("next", 1'h1, bus_oe)
    pin(1'h1, 1'h0);
    w(5);
    `CHK("release", 1'h0, bus_oe)
  endtask
  task automatic test_gate;
    mode(DEV_SLEEP);
    wr(`LIN_CTRL_OFS, 32'h2);
    rd(`LIN_INFO_OFS, 32'h3, 32'h0, "applied");
    wr(`LIN_CTRL_OFS, 32'h3);
    pin(1'h0, 1'h0);
    w(EN + 10);
    `CHK("sleep_drv", 1'h0, bus_oe)
    rd(`LIN_INFO_OFS, 32'h3, 32'h0, "applied");
    pin(1'h1, 1'h0);
    mode(DEV_FAILSAFE);
    rd(`LIN_INFO_OFS, 32'h3, 32'h1, "failsafe");
  endtask
  task automatic test_rxo;
    mode(DEV_STOP);
    wr(`LIN_CTRL_OFS, 32'h2);
    rd(`LIN_INFO_OFS, 32'h3, 32'h2, "applied");
    pin(1'h0, 1'h1);
    w(5);
    `CHK("rxo_drv", 1'h0, bus_oe)
    `CHK("rxo_rx", 1'h0, rx)
    pin(1'h1, 1'h0);
    w(5);
    `CHK("rxo_rx", 1'h1, rx)
  endtask
  task automatic test_wake;
    mode(DEV_NORMAL);
    wr(`LIN_CTRL_OFS, 32'h1);
    pin(1'h1, 1'h1);
    w(WK - 5);
    pin(1'h1, 1'h0);
    w(5);
    rd(`LIN_STAT_OFS, 32'h3, 32'h0, "short");
    pin(1'h1, 1'h1);
    w(WK + 5);
    pin(1'h1, 1'h0);
    w(5);
    `CHK("masked", 1'h0, irq)
    rd(`LIN_CTRL_OFS, 32'h3, 32'h1, "ctrl");
    `CHK("wake_rx", 1'h0, rx)
    wr(`LIN_MASK_OFS, 32'h1);
    w(2);
    `CHK("irq", 1'h1, irq)
    rd(`LIN_STAT_OFS, 32'h3, 32'h1, "status");
    w(2);
    `CHK("irq_clr", 1'h0, irq)
    wr(`LIN_CTRL_OFS, 32'h0);
    w(5);
    `CHK("rx_free", 1'h1, rx)
  endtask
  task automatic test_done;
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'h1;
    w(2);
    test_reset();
    test_off();
    test_norm();
    test_gate();
    test_rxo();
    test_wake();
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
